// [design/par_relay_logic.v]
// What this block does
// - danger relay trips only after violation persists the chosen 1 to 3 second delay.
// - the shutdown delay comes out of reset at one second.
// - every channel has its own alert; the axial pair shares one alert.
// - displayed values are reloaded once every second.
// - each bearing displays the larger of its two radial readings.
// - each case displays its highest temperature, casing vibration and rod drop.
// - axial positions and speed channels are displayed one by one.
// - display can show any value, either setpoint and each gap voltage.
// - alert and shutdown outputs are bypassed during adjustment, manual or automatic.
// - zero, gain and setpoints change only behind an unlock key.
// - vibration, position and rod drop values use steps finer than 2 percent.
// - temperature values resolve one degree.
// - speed values resolve one rpm.
// - one alert and one danger relay per variable type of the train.
// - a single circuit-fault relay serves the whole monitor.
// - one circuit fault removes its own channel from protection and, under radial dual voting, its partner's danger vote too.
// - separate phase reference inputs are accepted for each train or case.
// - radial and axial channels have own gain, default 7.87 mV per micrometre.
// - a host can read all measurement data except the gap voltages over the register bus.
// - dual voting needs both channels over danger (a failed axial one counts); one radial failure raises only fault, an axial one also alert.
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`include "par_defs.vh"

module par_relay_logic #(
   parameter MS_CYCLES = `PAR_MS_CYCLES
) (
   input  wire                                 core_clk,
   input  wire                                 rstn,
   input  wire                                 ce,
   input  wire [5:0]                           avs_address,
   input  wire                                 avs_read,
   input  wire                                 avs_write,
   input  wire [31:0]                          avs_writedata,
   input  wire [3:0]                           avs_byteenable,
   output wire [31:0]                          avs_readdata,
   output wire                                 avs_waitrequest,
   input  wire [`PAR_NCH*`PAR_VAL_W-1:0]       ch_value,
   input  wire [`PAR_NCH*`PAR_VAL_W-1:0]       ch_gap,
   input  wire [`PAR_NCH-1:0]                  ch_fault,
   input  wire [`PAR_SPD_W-1:0]                tach_rpm,
   input  wire [`PAR_SPD_W-1:0]                ovs_rpm,
   input  wire [`PAR_NPHASE-1:0]               phase_ref,
   output wire [`PAR_NTYPE-1:0]                alert_relay,
   output wire [`PAR_NTYPE-1:0]                danger_relay,
   output wire                                 fault_relay,
   output wire [`PAR_NCH-1:0]                  ch_alert,
   output wire                                 axial_pair_alert,
   output wire                                 bypass_active,
   output wire [`PAR_NSLOT*`PAR_DISP_W-1:0]    disp_slots,
   output wire [`PAR_DISP_W-1:0]               disp_view,
   output wire                                 disp_strobe
);

   localparam integer MS_LAST = MS_CYCLES - 1;

   function integer chan_type;
      input integer ch;
      begin
         if (ch < 4)
            chan_type = `PAR_T_RAD;
         else if (ch < 6)
            chan_type = `PAR_T_AX;
         else if (ch < 8)
            chan_type = `PAR_T_CAS;
         else if (ch < 10)
            chan_type = `PAR_T_TMP;
         else
            chan_type = `PAR_T_ROD;
      end
   endfunction

   function [11:0] max12;
      input [11:0] a;
      input [11:0] b;
      begin
         max12 = (a > b) ? a : b;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   reg  [31:0]                     ctrl_reg;
   reg                             unlock_reg;
   reg  [5:0]                      view_sel_reg;
   reg  [`PAR_VAL_W-1:0]           alert_sp_reg  [0:`PAR_NTYPE-1];
   reg  [`PAR_VAL_W-1:0]           danger_sp_reg [0:`PAR_NTYPE-1];
   reg  [15:0]                     gain_reg      [0:`PAR_NGAIN-1];
   reg  [`PAR_VAL_W-1:0]           zero_reg      [0:`PAR_NGAIN-1];
   reg  [`PAR_NCH*`PAR_VAL_W-1:0]  val_reg;
   reg  [`PAR_NTYPE-1:0]           alert_relay_reg;
   reg  [`PAR_NTYPE-1:0]           danger_relay_reg;
   reg                             fault_relay_reg;
   reg  [`PAR_NCH-1:0]             ch_alert_reg;
   reg                             ax_alert_reg;
   reg                             ack_reg;
   reg  [31:0]                     rdata_reg;
   reg  [16:0]                     ms_cnt_reg;
   reg  [11:0]                     disp_cnt_reg;
   reg                             disp_strobe_reg;
   reg  [`PAR_NSLOT*`PAR_DISP_W-1:0] disp_reg;
   reg  [`PAR_DISP_W-1:0]          view_reg;
   reg  [`PAR_NPHASE-1:0]          phase_prev_reg;
   reg  [`PAR_NPHASE*16-1:0]       phase_cnt_reg;
   reg  [11:0]                     tmr_reg [0:`PAR_NTYPE-1];
   reg  [31:0]                     rd_mux;
   reg  [`PAR_DISP_W-1:0]          view_next;

   wire [`PAR_NCH*`PAR_VAL_W-1:0]  scaled_w;
   wire [`PAR_NCH-1:0]             over_a;
   wire [`PAR_NCH-1:0]             over_d;
   wire [`PAR_NTYPE-1:0]           viol;
   wire [`PAR_NTYPE-1:0]           alert_any;
   wire [1:0]                      dly_s    = ctrl_reg[`PAR_CTRL_DLY_MSB:`PAR_CTRL_DLY_LSB];
   wire [11:0]                     dly_lim  = {10'h000, dly_s} * `PAR_MS_PER_S + 12'h001;
   wire                            bypass   = ctrl_reg[`PAR_CTRL_BYP] | unlock_reg;
   wire                            ms_tick  = ce & (ms_cnt_reg == MS_LAST[16:0]);
   wire                            wr_en    = ce & avs_write & ack_reg & (avs_byteenable == 4'hF);
   wire [5:0]                      a        = avs_address;
   wire [5:0]                      a_alert  = a - `PAR_OFS_ALERT;
   wire [5:0]                      a_danger = a - `PAR_OFS_DANGER;
   wire [5:0]                      a_gain   = a - `PAR_OFS_GAIN;
   wire [5:0]                      a_zero   = a - `PAR_OFS_ZERO;
   wire [5:0]                      a_val    = a - `PAR_OFS_VAL;
   wire [5:0]                      a_phase  = a - `PAR_OFS_PHASE;
   wire [31:0]                     wd       = avs_writedata;

   ////////////////////////////////////////////////////////////////////////////
   // per channel scaling and setpoint comparison
   genvar i;
   generate
      for (i = 0; i < `PAR_NCH; i = i + 1) begin : g_ch
         wire [11:0] raw = ch_value[i*12 +: 12];
         wire [11:0] v   = val_reg[i*12 +: 12];
         if (i < `PAR_NGAIN) begin : g_gain
            wire signed [12:0] diff = $signed({1'b0, raw}) - $signed({1'b0, zero_reg[i]});
            wire signed [29:0] prod = diff * $signed({1'b0, gain_reg[i]});
            assign scaled_w[i*12 +: 12] = prod[29] ? 12'h000 :
                                          (|prod[28:20]) ? 12'hFFF : prod[19:8];
         end else begin : g_pass
            assign scaled_w[i*12 +: 12] = raw;
         end
         // a faulted channel drops out of its own votes only
         assign over_a[i] = ~ch_fault[i] & (v >= alert_sp_reg[chan_type(i)]);
         assign over_d[i] = ~ch_fault[i] & (v >= danger_sp_reg[chan_type(i)]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // voting per variable type
   wire srad = ctrl_reg[`PAR_CTRL_SRAD];
   wire sax  = ctrl_reg[`PAR_CTRL_SAX];
   wire [1:0] fax = ch_fault[5:4];
   wire [1:0] dax = over_d[5:4];
   assign viol[`PAR_T_RAD] = srad ? (|over_d[3:0]) :
                             ((over_d[0] & over_d[1]) | (over_d[2] & over_d[3]));
   assign viol[`PAR_T_AX]  = sax ? (|dax) :
                             ((&dax) | (&fax) | (fax[0] & dax[1]) | (fax[1] & dax[0]));
   assign viol[`PAR_T_CAS] = |over_d[7:6];
   assign viol[`PAR_T_TMP] = |over_d[9:8];
   assign viol[`PAR_T_ROD] = |over_d[11:10];
   assign alert_any[`PAR_T_RAD] = |over_a[3:0];
   assign alert_any[`PAR_T_AX]  = (|over_a[5:4]) | (|fax);
   assign alert_any[`PAR_T_CAS] = |over_a[7:6];
   assign alert_any[`PAR_T_TMP] = |over_a[9:8];
   assign alert_any[`PAR_T_ROD] = |over_a[11:10];

   ////////////////////////////////////////////////////////////////////////////
   // sustained-violation timers, one per type
   genvar t;
   generate
      for (t = 0; t < `PAR_NTYPE; t = t + 1) begin : g_tmr
         always @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               tmr_reg[t] <= 12'h000;
            end else if (ce) begin
               if (bypass || !viol[t])
                  tmr_reg[t] <= 12'h000;
               else if (ms_tick && tmr_reg[t] < dly_lim)
                  tmr_reg[t] <= tmr_reg[t] + 12'h001;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // relays and alerts
   integer k, kp, kb;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         val_reg          <= {(`PAR_NCH*`PAR_VAL_W){1'b0}};
         alert_relay_reg  <= {`PAR_NTYPE{1'b0}};
         danger_relay_reg <= {`PAR_NTYPE{1'b0}};
         fault_relay_reg  <= 1'b0;
         ch_alert_reg     <= {`PAR_NCH{1'b0}};
         ax_alert_reg     <= 1'b0;
      end else if (ce) begin
         val_reg         <= scaled_w;
         fault_relay_reg <= |ch_fault;
         for (k = 0; k < `PAR_NTYPE; k = k + 1) begin
            alert_relay_reg[k]  <= ~bypass & alert_any[k];
            danger_relay_reg[k] <= ~bypass & viol[k] & (tmr_reg[k] >= dly_lim);
         end
         ch_alert_reg <= bypass ? {`PAR_NCH{1'b0}} : over_a;
         ax_alert_reg <= ~bypass & alert_any[`PAR_T_AX];
      end
   end

   assign alert_relay      = alert_relay_reg;
   assign danger_relay     = danger_relay_reg;
   assign fault_relay      = fault_relay_reg;
   assign ch_alert         = ch_alert_reg;
   assign axial_pair_alert = ax_alert_reg;
   assign bypass_active    = bypass;

   ////////////////////////////////////////////////////////////////////////////
   // millisecond base, display refresh and phase reference counters
   always @* begin
      view_next = 16'h0000;
      case (view_sel_reg[5:4])
         2'h0: view_next = (view_sel_reg[3:0] < 4'hC) ? {4'h0, val_reg[view_sel_reg[3:0]*12 +: 12]} : 16'h0000;
         2'h1: view_next = (view_sel_reg[3:0] < 4'hC) ? {4'h0, ch_gap[view_sel_reg[3:0]*12 +: 12]} : 16'h0000;
         2'h2: view_next = (view_sel_reg[3:0] < 4'h5) ? {4'h0, alert_sp_reg[view_sel_reg[2:0]]} : 16'h0000;
         2'h3: view_next = (view_sel_reg[3:0] < 4'h5) ? {4'h0, danger_sp_reg[view_sel_reg[2:0]]} : 16'h0000;
         default: view_next = 16'h0000;
      endcase
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ms_cnt_reg      <= 17'h00000;
         disp_cnt_reg    <= 12'h000;
         disp_strobe_reg <= 1'b0;
         disp_reg        <= {(`PAR_NSLOT*`PAR_DISP_W){1'b0}};
         view_reg        <= 16'h0000;
         phase_prev_reg  <= {`PAR_NPHASE{1'b0}};
         phase_cnt_reg   <= {(`PAR_NPHASE*16){1'b0}};
      end else if (ce) begin
         ms_cnt_reg      <= ms_tick ? 17'h00000 : ms_cnt_reg + 17'h00001;
         disp_strobe_reg <= 1'b0;
         if (ms_tick) begin
            if (disp_cnt_reg == `PAR_DISP_TIME_MS - 12'h001) begin
               disp_cnt_reg    <= 12'h000;
               disp_strobe_reg <= 1'b1;
               disp_reg[0*16 +: 16] <= {4'h0, max12(val_reg[0 +: 12], val_reg[12 +: 12])};
               disp_reg[1*16 +: 16] <= {4'h0, max12(val_reg[24 +: 12], val_reg[36 +: 12])};
               disp_reg[2*16 +: 16] <= {4'h0, val_reg[48 +: 12]};
               disp_reg[3*16 +: 16] <= {4'h0, val_reg[60 +: 12]};
               disp_reg[4*16 +: 16] <= {4'h0, max12(val_reg[72 +: 12], val_reg[84 +: 12])};
               disp_reg[5*16 +: 16] <= {4'h0, max12(val_reg[96 +: 12], val_reg[108 +: 12])};
               disp_reg[6*16 +: 16] <= {4'h0, max12(val_reg[120 +: 12], val_reg[132 +: 12])};
               disp_reg[7*16 +: 16] <= tach_rpm;
               disp_reg[8*16 +: 16] <= ovs_rpm;
               view_reg        <= view_next;
            end else begin
               disp_cnt_reg <= disp_cnt_reg + 12'h001;
            end
         end
         phase_prev_reg <= phase_ref;
         for (kp = 0; kp < `PAR_NPHASE; kp = kp + 1)
            if (phase_ref[kp] & ~phase_prev_reg[kp])
               phase_cnt_reg[kp*16 +: 16] <= phase_cnt_reg[kp*16 +: 16] + 16'h0001;
      end
   end

   assign disp_slots  = disp_reg;
   assign disp_view   = view_reg;
   assign disp_strobe = disp_strobe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // register bus: one wait state on every access
   always @* begin
      rd_mux = 32'h00000000;
      if (a == `PAR_OFS_CTRL)
         rd_mux = ctrl_reg;
      else if (a == `PAR_OFS_KEY)
         rd_mux = {31'h00000000, unlock_reg};
      else if (a == `PAR_OFS_STAT)
         rd_mux = {8'h00, ch_alert_reg, bypass, fault_relay_reg, danger_relay_reg, alert_relay_reg};
      else if (a == `PAR_OFS_VIEW)
         rd_mux = {26'h0000000, view_sel_reg};
      else if (a_alert < 6'h05)
         rd_mux = {20'h00000, alert_sp_reg[a_alert[2:0]]};
      else if (a_danger < 6'h05)
         rd_mux = {20'h00000, danger_sp_reg[a_danger[2:0]]};
      else if (a_gain < 6'h06)
         rd_mux = {16'h0000, gain_reg[a_gain[2:0]]};
      else if (a_zero < 6'h06)
         rd_mux = {20'h00000, zero_reg[a_zero[2:0]]};
      else if (a_val < 6'h0C)
         rd_mux = {20'h00000, val_reg[a_val[3:0]*12 +: 12]};
      else if (a_phase < 6'h02)
         rd_mux = {16'h0000, phase_cnt_reg[a_phase[0]*16 +: 16]};
      else if (a == `PAR_OFS_TACH)
         rd_mux = {16'h0000, tach_rpm};
      else if (a == `PAR_OFS_OVS)
         rd_mux = {16'h0000, ovs_rpm};
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign avs_readdata    = rdata_reg;

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ack_reg      <= 1'b0;
         rdata_reg    <= 32'h00000000;
         ctrl_reg     <= `PAR_CTRL_RST;
         unlock_reg   <= 1'b0;
         view_sel_reg <= 6'h00;
         for (kb = 0; kb < `PAR_NTYPE; kb = kb + 1) begin
            alert_sp_reg[kb]  <= `PAR_ALERT_RST;
            danger_sp_reg[kb] <= `PAR_DANGER_RST;
         end
         for (kb = 0; kb < `PAR_NGAIN; kb = kb + 1) begin
            gain_reg[kb] <= `PAR_GAIN_RST;
            zero_reg[kb] <= `PAR_ZERO_RST;
         end
      end else if (ce) begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
         if (avs_read & ~ack_reg)
            rdata_reg <= rd_mux;
         if (wr_en) begin
            if (a == `PAR_OFS_CTRL) begin
               ctrl_reg[`PAR_CTRL_BYP]  <= wd[`PAR_CTRL_BYP];
               if (unlock_reg) begin
                  ctrl_reg[`PAR_CTRL_SRAD] <= wd[`PAR_CTRL_SRAD];
                  ctrl_reg[`PAR_CTRL_SAX]  <= wd[`PAR_CTRL_SAX];
                  if (wd[`PAR_CTRL_DLY_MSB:`PAR_CTRL_DLY_LSB] >= `PAR_DLY_MIN_S &&
                      wd[`PAR_CTRL_DLY_MSB:`PAR_CTRL_DLY_LSB] <= `PAR_DLY_MAX_S)
                     ctrl_reg[`PAR_CTRL_DLY_MSB:`PAR_CTRL_DLY_LSB] <=
                        wd[`PAR_CTRL_DLY_MSB:`PAR_CTRL_DLY_LSB];
               end
            end
            if (a == `PAR_OFS_KEY)
               unlock_reg <= (wd == `PAR_KEY);
            if (a == `PAR_OFS_VIEW)
               view_sel_reg <= wd[5:0];
            if (unlock_reg) begin
               if (a_alert < 6'h05)
                  alert_sp_reg[a_alert[2:0]] <= wd[11:0];
               if (a_danger < 6'h05)
                  danger_sp_reg[a_danger[2:0]] <= wd[11:0];
               if (a_gain < 6'h06)
                  gain_reg[a_gain[2:0]] <= wd[15:0];
               if (a_zero < 6'h06)
                  zero_reg[a_zero[2:0]] <= wd[11:0];
            end
         end
      end
   end

endmodule // par_relay_logic

// [design/par_defs.vh]
`ifndef PAR_DEFS_VH
`define PAR_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// widths
`define PAR_VAL_W          12
`define PAR_SPD_W          16
`define PAR_DISP_W         16
`define PAR_NCH            12
`define PAR_NTYPE          5
`define PAR_NGAIN          6
`define PAR_NPHASE         2
`define PAR_NSLOT          9

////////////////////////////////////////////////////////////////////////////////
// timing
`define PAR_CLK_PERIOD_NS  10
`define PAR_MS_TIME_NS     1000000
`define PAR_MS_CYCLES      (`PAR_MS_TIME_NS / `PAR_CLK_PERIOD_NS)
`define PAR_DISP_TIME_MS   12'd1000
`define PAR_MS_PER_S       12'd1000
`define PAR_DLY_MIN_S      2'd1
`define PAR_DLY_MAX_S      2'd3

////////////////////////////////////////////////////////////////////////////////
// reset values
`define PAR_DLY_RST_S      2'd1
`define PAR_GAIN_RST       16'h0100
`define PAR_ZERO_RST       12'h000
`define PAR_ALERT_RST      12'hC00
`define PAR_DANGER_RST     12'hE00
`define PAR_CTRL_RST       32'h00000100
// unlock key value is arbitrary
`define PAR_KEY            32'hC0DE5AFE

////////////////////////////////////////////////////////////////////////////////
// register word indexes
`define PAR_OFS_CTRL       6'h00
`define PAR_OFS_KEY        6'h01
`define PAR_OFS_STAT       6'h02
`define PAR_OFS_VIEW       6'h03
`define PAR_OFS_ALERT      6'h04
`define PAR_OFS_DANGER     6'h09
`define PAR_OFS_GAIN       6'h0E
`define PAR_OFS_ZERO       6'h14
`define PAR_OFS_VAL        6'h1A
`define PAR_OFS_PHASE      6'h26
`define PAR_OFS_TACH       6'h28
`define PAR_OFS_OVS        6'h29

////////////////////////////////////////////////////////////////////////////////
// control fields
`define PAR_CTRL_BYP       0
`define PAR_CTRL_SRAD      1
`define PAR_CTRL_SAX       2
`define PAR_CTRL_DLY_LSB   8
`define PAR_CTRL_DLY_MSB   9

////////////////////////////////////////////////////////////////////////////////
// variable types, also relay bit order
`define PAR_T_AX           0
`define PAR_T_RAD          1
`define PAR_T_CAS          2
`define PAR_T_TMP          3
`define PAR_T_ROD          4

`endif

// [tb/par_relay_chk.sv]
`timescale 1ns/100ps
`include "par_defs.vh"
module par_relay_chk #(
   parameter MS_CYCLES = 4
) (
   input wire                           core_clk,
   input wire                           rstn,
   input wire                           avs_read,
   input wire                           avs_write,
   input wire                           avs_waitrequest,
   input wire [`PAR_NCH*`PAR_VAL_W-1:0] ch_value,
   input wire [`PAR_NCH-1:0]            ch_fault,
   input wire [`PAR_NTYPE-1:0]          alert_relay,
   input wire [`PAR_NTYPE-1:0]          danger_relay,
   input wire                           fault_relay,
   input wire [`PAR_NCH-1:0]            ch_alert,
   input wire                           axial_pair_alert,
   input wire                           bypass_active,
   input wire                           disp_strobe
);
   localparam integer SEC = 1000 * MS_CYCLES;
   reg [31:0] still_reg;
   reg [31:0] gap_reg;
   // cycles since channel inputs last moved, and since the last display reload
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         still_reg <= 32'h0;
         gap_reg   <= 32'h0;
      end else begin
         still_reg <= $changed(ch_value) ? 32'h0 : still_reg + 32'h1;
         gap_reg   <= disp_strobe ? 32'h0 : gap_reg + 32'h1;
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_req; $rose(avs_read | avs_write); endsequence
   sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
   sequence s_ax_down; ((ch_fault[4] | ch_fault[5]) && !bypass_active) [*2]; endsequence
   property p_wait; s_req |-> s_one_wait; endproperty
   a_wait: assert property (p_wait) else $error("bus answer not after one wait state");
   property p_byp; bypass_active |=> (alert_relay | danger_relay) == 5'h00 && ch_alert == 12'h000; endproperty
   a_byp: assert property (p_byp) else $error("relay set while bypassed");
   property p_flt; fault_relay == |$past(ch_fault); endproperty
   a_flt: assert property (p_flt) else $error("fault relay does not follow channel faults");
   property p_flt_alert; (ch_alert & $past(ch_fault) & $past(ch_fault, 2)) == 12'h000; endproperty
   a_flt_alert: assert property (p_flt_alert) else $error("alert from failed channel");
   property p_ax_flt; s_ax_down |=> axial_pair_alert; endproperty
   a_ax_flt: assert property (p_ax_flt) else $error("axial pair alert missing on fault");
   property p_dng; $rose(|danger_relay) |-> still_reg >= SEC; endproperty
   a_dng: assert property (p_dng) else $error("danger relay before sustained delay");
   property p_gap; gap_reg <= SEC + 4; endproperty
   a_gap: assert property (p_gap) else $error("display reload overdue");
   property p_strobe; disp_strobe |-> (gap_reg >= SEC - 4) ##1 !disp_strobe; endproperty
   a_strobe: assert property (p_strobe) else $error("display reload pulse wrong");
endmodule // par_relay_chk

// [tb/par_shutdown_loop.sv]
`timescale 1ns/100ps
`include "par_defs.vh"
module par_shutdown_loop (
   input  wire                  core_clk,
   input  wire                  rstn,
   input  wire [`PAR_NTYPE-1:0] danger_relay,
   output reg                   machine_trip
);
   // trip latches from the danger relays alone; data outputs never reach the loop
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         machine_trip <= 1'h0;
      else if (|danger_relay)
         machine_trip <= 1'h1;
   end
endmodule // par_shutdown_loop

// [tb/par_relay_logic_tb_top.sv]
`timescale 1ns/100ps
`include "par_defs.vh"
module par_relay_logic_tb_top;
   localparam integer MS = 4;
   reg          core_clk = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
   reg  [5:0]   avs_address = 6'h00;
   reg  [31:0]  avs_writedata = 32'h0, q;
   reg  [143:0] ch_value = 144'h0, ch_gap = 144'h0;
   reg  [11:0]  ch_fault = 12'h000;
   reg  [15:0]  tach_rpm = 16'h0E11, ovs_rpm = 16'h0E13;
   reg  [1:0]   phase_ref = 2'h0;
   reg  [15:0]  ex [0:8];
   wire [31:0]  avs_readdata;
   wire [4:0]   alert_relay, danger_relay;
   wire [11:0]  ch_alert;
   wire [143:0] disp_slots;
   wire [15:0]  disp_view;
   wire         avs_waitrequest, fault_relay, axial_pair_alert, bypass_active, disp_strobe, machine_trip;
   integer      miscompares = 0, n_compared = 0, k;
   always #5 core_clk = ~core_clk;
   par_relay_logic #(.MS_CYCLES(MS)) DUT (
      .core_clk(core_clk), .rstn(rstn), .ce(1'h1), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ch_value(ch_value), .ch_gap(ch_gap),
      .ch_fault(ch_fault), .tach_rpm(tach_rpm), .ovs_rpm(ovs_rpm), .phase_ref(phase_ref),
      .alert_relay(alert_relay), .danger_relay(danger_relay), .fault_relay(fault_relay), .ch_alert(ch_alert),
      .axial_pair_alert(axial_pair_alert), .bypass_active(bypass_active), .disp_slots(disp_slots),
      .disp_view(disp_view), .disp_strobe(disp_strobe));
   par_shutdown_loop u_loop (.core_clk(core_clk), .rstn(rstn), .danger_relay(danger_relay),
      .machine_trip(machine_trip));
   ////////////////////////////////////////
   task stop_test;
      if (miscompares == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task timeout;
      miscompares = miscompares + 1;
      stop_test;
   endtask
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one request, held until waitrequest is sampled low
   task bus(input wr, input [5:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge core_clk);
         avs_address <= a;
         avs_writedata <= d;
         avs_read <= !wr;
         avs_write <= wr;
         n = 0;
         @(posedge core_clk);
         while (avs_waitrequest !== 1'h0 && n < 20) begin
            @(posedge core_clk);
            n = n + 1;
         end
         if (n == 20)
            timeout;
         q = avs_readdata;
         avs_read <= 1'h0;
         avs_write <= 1'h0;
      end
   endtask
   task rdc(input [5:0] a, input [31:0] e);
      bus(1'h0, a, 32'h0);
      chk("register", q, e);
   endtask
   // sel high waits for the radial danger relay, low for a display reload
   task wfor(input sel, input integer n);
      integer i;
      begin
         i = 0;
         @(posedge core_clk);
         while ((sel ? danger_relay[1] : disp_strobe) !== 1'h1 && i < n) begin
            @(posedge core_clk);
            i = i + 1;
         end
         if (i == n)
            timeout;
      end
   endtask
   function [11:0] vt(input integer i);
      vt = 12'h100 + ((i * 5) % 7) * 12'h040;
   endfunction
   function [11:0] mx(input integer a);
      mx = (vt(a) > vt(a + 1)) ? vt(a) : vt(a + 1);
   endfunction
   function integer ty(input integer i);
      ty = (i < 4) ? 1 : (i < 6) ? 0 : i / 2 - 1;
   endfunction
   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge core_clk);
      rstn <= 1'h1;
      rdc(`PAR_OFS_CTRL, 32'h100);
      rdc(`PAR_OFS_DANGER + 6'h1, 32'hE00);
      rdc(`PAR_OFS_GAIN, 32'h100);
      rdc(6'h3F, 32'h0);
      bus(1'h1, `PAR_OFS_ALERT + 6'h1, 32'h800);
      rdc(`PAR_OFS_ALERT + 6'h1, 32'hC00);
      bus(1'h1, `PAR_OFS_KEY, `PAR_KEY);
      @(posedge core_clk);
      chk("bypass", bypass_active, 1'h1);
      bus(1'h1, `PAR_OFS_ALERT + 6'h1, 32'h800);
      bus(1'h1, `PAR_OFS_DANGER + 6'h1, 32'hA00);
      bus(1'h1, `PAR_OFS_CTRL, 32'h200);
      bus(1'h1, `PAR_OFS_KEY, 32'h0);
      rdc(`PAR_OFS_ALERT + 6'h1, 32'h800);
      rdc(`PAR_OFS_CTRL, 32'h200);
      chk("bypass", bypass_active, 1'h0);
      for (k = 0; k < 4; k = k + 1) begin
         @(posedge core_clk);
         phase_ref <= (k == 3) ? 2'h2 : 2'h1;
         @(posedge core_clk);
         phase_ref <= 2'h0;
      end
      rdc(`PAR_OFS_PHASE, 32'h3);
      rdc(`PAR_OFS_PHASE + 6'h1, 32'h1);
      for (k = 0; k < 12; k = k + 1) begin
         @(posedge core_clk);
         ch_value <= 144'hD00 << (12 * k);
         repeat (3) @(posedge core_clk);
         chk("ch_alert", ch_alert, 12'h001 << k);
         chk("alert_relay", alert_relay, 5'h01 << ty(k));
         chk("axial_pair", axial_pair_alert, k == 4 || k == 5);
      end
      for (k = 0; k < 12; k = k + 1) begin
         ch_value[12*k +: 12] <= vt(k);
         ch_gap[12*k +: 12] <= 12'h800 + k;
      end
      bus(1'h1, `PAR_OFS_VIEW, 32'h13);
      ex[0] = mx(0);
      ex[1] = mx(2);
      ex[2] = vt(4);
      ex[3] = vt(5);
      ex[4] = mx(6);
      ex[5] = mx(8);
      ex[6] = mx(10);
      ex[7] = tach_rpm;
      ex[8] = ovs_rpm;
      wfor(1'h0, 5000);
      wfor(1'h0, 5000);
      for (k = 0; k < 9; k = k + 1)
         chk("slot", disp_slots[16*k +: 16], ex[k]);
      chk("view", disp_view, 16'h803);
      rdc(`PAR_OFS_VAL + 6'h3, vt(3));
      rdc(`PAR_OFS_TACH, 32'hE11);
      ch_value[23:0] <= 24'hF00F00;
      repeat (6000) @(posedge core_clk);
      ch_value[11:0] <= 12'h100;
      repeat (4) @(posedge core_clk);
      ch_value[11:0] <= 12'hF00;
      repeat (2000 * MS - 10) @(posedge core_clk);
      chk("danger", danger_relay, 5'h00);
      wfor(1'h1, 40);
      chk("danger", danger_relay, 5'h02);
      bus(1'h1, `PAR_OFS_CTRL, 32'h201);
      chk("trip", machine_trip, 1'h1);
      repeat (3) @(posedge core_clk);
      chk("danger", danger_relay | alert_relay, 5'h00);
      bus(1'h1, `PAR_OFS_CTRL, 32'h200);
      wfor(1'h1, 8100);
      ch_fault <= 12'h012;
      repeat (3) @(posedge core_clk);
      chk("danger", danger_relay, 5'h00);
      chk("fault", fault_relay, 1'h1);
      chk("axial_pair", axial_pair_alert, 1'h1);
      chk("ch_alert", ch_alert & 12'h012, 12'h000);
      repeat (2) @(posedge core_clk);
      stop_test;
   end
endmodule // par_relay_logic_tb_top
bind par_relay_logic par_relay_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
   .core_clk(core_clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .ch_value(ch_value), .ch_fault(ch_fault), .alert_relay(alert_relay),
   .danger_relay(danger_relay), .fault_relay(fault_relay), .ch_alert(ch_alert),
   .axial_pair_alert(axial_pair_alert), .bypass_active(bypass_active), .disp_strobe(disp_strobe));
